// ==== hdl/pds_pkg.sv ====
package pds_pkg;
	// ==========================================
	// Sizes and field layout
	localparam int NRGN = 32;
	localparam int IDXW = 5;
	localparam int ADDR_LSB = 6;
	localparam int AW = 26;
	localparam int B_SH = 3;
	localparam int B_AP = 1;
	localparam int B_XN = 0;
	localparam int L_ATTR = 1;
	localparam int L_EN = 0;
	localparam logic [31:0] INSN_TOP = 32'h7fffffff;
	localparam logic [31:0] WB_TOP = 32'h3fffffff;
	localparam logic [31:0] WT_TOP = 32'h5fffffff;
	localparam logic [31:0] NC_TOP = 32'h7fffffff;
	localparam logic [31:0] DEV_E_BASE = 32'h80000000;
	localparam logic [31:0] DEV_NE_BASE = 32'hc0000000;
	localparam logic [1:0] FAULT_LEVEL = 2'h0;
	// Query result fields
	localparam int Q_F = 0;
	localparam int Q_FK = 1;
	localparam int Q_LV = 3;
	localparam int Q_PA = 12;
	localparam int Q_AT = 32;
	// ==========================================
	// Types
	// Ordered so the stricter type is the lower code
	typedef enum logic [2:0] {MT_DEV_SO, MT_DEV_PW, MT_NORM_NC, MT_NORM_WT,
		MT_NORM_WB} pds_mem_t;
	typedef enum logic [1:0] {LVL_APP, LVL_KERNEL, LVL_HYP} pds_lvl_t;
	typedef enum logic [1:0] {FK_NONE, FK_S1_PERM, FK_S2_PERM, FK_BG} pds_fault_t;
	typedef enum logic [2:0] {OP_SELECT, OP_BASE, OP_LIMIT, OP_DBASE, OP_DLIMIT,
		OP_ENABLES} pds_op_t;
	typedef struct packed {
		pds_mem_t mem;
		logic share;
		logic xn;
	} pds_attr_t;
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
	} pds_rgn_t;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic fetch;
		logic write;
		pds_lvl_t lvl;
		logic debug;
	} pds_req_t;
	typedef struct packed {
		logic valid;
		pds_attr_t attr;
		pds_fault_t fault;
		logic [1:0] level;
		logic debug_event;
		logic [63:0] query;
	} pds_resp_t;
	typedef struct packed {
		logic wr;
		logic hyp;
		pds_op_t op;
		logic [IDXW-1:0] idx;
		logic [31:0] wdata;
	} pds_cfg_t;
	localparam pds_attr_t DC_ATTR = '{mem: MT_NORM_WB, share: 1'b0, xn: 1'b0};
endpackage : pds_pkg

// ==== hdl/pds_select.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Each unit applies its own default map to all accesses while disabled.
// [RULE2] Enabled unit with background on: privileged misses are checked on background.
// [RULE3] Kernel background checking only while kernel_background_enable is one.
// [RULE4] Hypervisor background checking only while hyp_background_enable is one.
// [RULE5] Override zero: kernel background uses the kernel default map.
// [RULE6] Kernel fetch map: low half executable, cache enable picks attributes.
// [RULE7] Kernel data map low 2GB split by data-cache enable.
// [RULE8] Data from 0x80000000 posted device, from 0xC0000000 strictly ordered.
// [RULE9] Override one: normal, non-shareable, executable, write-back allocate.
// [RULE10] Hypervisor unit uses its default map when disabled and as background.
// [RULE11] Hypervisor fetch map matches kernel one, chosen by hyp_icache_enable.
// [RULE12] Hypervisor data map matches kernel one, chosen by hyp_dcache_enable.
// [RULE13] Address compared to regions; hit or background sets permission and attributes.
// [RULE14] Units enabled exactly while their unit-enable bits are one.
// [RULE15] Select register steers base and limit accesses to one region.
// [RULE16] Directly indexed base and limit pairs for regions 0 to 31.
// [RULE17] Hypervisor region-enable word reaches enable bits of regions 0-31.
// [RULE18] Faults are level 0; query returns 64-bit result from full address.
// [RULE19] With halting_debug_disable, stage 2 faults in debug are debug events.
// [RULE20] Hypervisor access: hyp unit when enabled, else hyp background.
// [RULE21] Kernel/app stage 1: kernel unit when enabled, else kernel background.
// [RULE22] Second stage on: combine with hyp unit or hyp background.
// [RULE23] Stage 1 denial wins; stage 2 fault only when stage 1 permits.
// [RULE24] Device at either stage wins; stricter device properties prevail.
// [RULE25] Miss with no usable background raises a background fault.
module pds_select (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Control bits
	input wire logic kernel_unit_enable,
	input wire logic hyp_unit_enable,
	input wire logic kernel_background_enable,
	input wire logic hyp_background_enable,
	input wire logic default_cacheable_override,
	input wire logic second_stage_enable,
	input wire logic kernel_icache_enable,
	input wire logic kernel_dcache_enable,
	input wire logic hyp_icache_enable,
	input wire logic hyp_dcache_enable,
	input wire logic halting_debug_disable,
	// Region programming
	input wire pds_pkg::pds_cfg_t cfg,
	output logic [31:0] cfg_rdata,
	// Access check
	input wire pds_pkg::pds_req_t req,
	output pds_pkg::pds_resp_t resp
);
	// ==========================================
	// State
	typedef struct packed {
		pds_pkg::pds_rgn_t [pds_pkg::NRGN-1:0] krgn;
		pds_pkg::pds_rgn_t [pds_pkg::NRGN-1:0] hrgn;
		logic [pds_pkg::IDXW-1:0] ksel;
		logic [pds_pkg::IDXW-1:0] hsel;
		logic [31:0] rdata;
		pds_pkg::pds_resp_t resp;
	} pds_state_t;

	pds_state_t st;
	pds_state_t next_st;
	logic [1:0] rst_sync;
	logic rst_n;

	// ==========================================
	// Reset release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ==========================================
	// Region hit vectors
	logic [pds_pkg::NRGN-1:0] khit;
	logic [pds_pkg::NRGN-1:0] hhit;
	genvar gi;
	generate
		for (gi = 0; gi < pds_pkg::NRGN; gi++) begin : g_hit
			assign khit[gi] = st.krgn[gi].limit[pds_pkg::L_EN] &&
				req.addr[31:pds_pkg::ADDR_LSB] >= st.krgn[gi].base[31:pds_pkg::ADDR_LSB] &&
				req.addr[31:pds_pkg::ADDR_LSB] <= st.krgn[gi].limit[31:pds_pkg::ADDR_LSB]; // RULE13
			assign hhit[gi] = st.hrgn[gi].limit[pds_pkg::L_EN] &&
				req.addr[31:pds_pkg::ADDR_LSB] >= st.hrgn[gi].base[31:pds_pkg::ADDR_LSB] &&
				req.addr[31:pds_pkg::ADDR_LSB] <= st.hrgn[gi].limit[31:pds_pkg::ADDR_LSB]; // RULE13
		end
	endgenerate

	// ==========================================
	// Helpers
	// Lowest numbered hit wins
	function automatic logic [pds_pkg::IDXW-1:0] first_hit(input logic [pds_pkg::NRGN-1:0] v);
		logic [pds_pkg::IDXW-1:0] r;
		r = '0;
		for (int i = pds_pkg::NRGN - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = pds_pkg::IDXW'(i);
			end
		end
		return r;
	endfunction : first_hit

	function automatic pds_pkg::pds_attr_t dmap(input logic [31:0] a, input logic f,
		input logic ic, input logic dc);
		pds_pkg::pds_attr_t r;
		r = '{mem: pds_pkg::MT_NORM_NC, share: 1'b1, xn: 1'b0};
		if (f) begin
			if (a > pds_pkg::INSN_TOP) begin
				r.xn = 1'b1; // RULE6 RULE11
			end else if (ic) begin
				r = '{mem: pds_pkg::MT_NORM_WT, share: 1'b0, xn: 1'b0}; // RULE6 RULE11
			end
		end else if (a >= pds_pkg::DEV_NE_BASE) begin
			r = '{mem: pds_pkg::MT_DEV_SO, share: 1'b1, xn: 1'b0}; // RULE8 RULE12
		end else if (a >= pds_pkg::DEV_E_BASE) begin
			r = '{mem: pds_pkg::MT_DEV_PW, share: 1'b1, xn: 1'b0}; // RULE8 RULE12
		end else if (dc && a <= pds_pkg::WB_TOP) begin
			r = '{mem: pds_pkg::MT_NORM_WB, share: 1'b0, xn: 1'b0}; // RULE7 RULE12
		end else if (dc && a <= pds_pkg::WT_TOP) begin
			r = '{mem: pds_pkg::MT_NORM_WT, share: 1'b0, xn: 1'b0}; // RULE7 RULE12
		end
		return r;
	endfunction : dmap

	function automatic pds_pkg::pds_attr_t rattr(input pds_pkg::pds_rgn_t g);
		pds_pkg::pds_attr_t r;
		logic [2:0] m;
		m = g.limit[pds_pkg::L_ATTR +: 3];
		// Spare codes fold to write-back rather than fault
		r.mem = (m > 3'(pds_pkg::MT_NORM_WB)) ? pds_pkg::MT_NORM_WB : pds_pkg::pds_mem_t'(m);
		r.share = g.base[pds_pkg::B_SH];
		r.xn = g.base[pds_pkg::B_XN];
		return r;
	endfunction : rattr

	// Access permission: bit1 read-only, bit0 unprivileged allowed
	function automatic logic perm_ok(input logic [1:0] ap, input logic xn, input logic priv,
		input logic w, input logic f);
		return !(f && xn) && !(w && ap[1]) && (priv || ap[0]);
	endfunction : perm_ok

	// ==========================================
	// Next state
	logic priv;
	logic s2_on;
	pds_pkg::pds_attr_t kbg;
	pds_pkg::pds_attr_t hbg;
	pds_pkg::pds_attr_t a1;
	pds_pkg::pds_attr_t a2;
	pds_pkg::pds_attr_t ac;
	logic ok1;
	logic ok2;
	logic bg1;
	logic bg2;
	pds_pkg::pds_rgn_t kr;
	pds_pkg::pds_rgn_t hr;
	logic [pds_pkg::IDXW-1:0] cidx;

	always_comb begin
		next_st = st;
		kr = st.krgn[first_hit(khit)];
		hr = st.hrgn[first_hit(hhit)];
		priv = req.lvl != pds_pkg::LVL_APP;
		// Background attributes
		kbg = default_cacheable_override ? pds_pkg::DC_ATTR : // RULE9
			dmap(req.addr, req.fetch, kernel_icache_enable, kernel_dcache_enable); // RULE5 RULE1
		hbg = dmap(req.addr, req.fetch, hyp_icache_enable, hyp_dcache_enable); // RULE10
		a2 = hbg;
		ok2 = 1'b1;
		bg2 = 1'b0;
		bg1 = 1'b0;
		// Stage 1
		if (req.lvl == pds_pkg::LVL_HYP) begin
			a1 = hbg;
			ok1 = !(req.fetch && hbg.xn);
			if (hyp_unit_enable) begin // RULE14 RULE20
				if (|hhit) begin
					a1 = rattr(hr);
					ok1 = perm_ok(hr.base[pds_pkg::B_AP +: 2], a1.xn, 1'b1, req.write,
						req.fetch);
				end else if (!hyp_background_enable) begin // RULE4 RULE2
					bg1 = 1'b1; // RULE25
				end
			end
		end else begin
			a1 = kbg;
			ok1 = !(req.fetch && kbg.xn);
			if (kernel_unit_enable) begin // RULE14 RULE21
				if (|khit) begin
					a1 = rattr(kr);
					ok1 = perm_ok(kr.base[pds_pkg::B_AP +: 2], a1.xn, priv, req.write,
						req.fetch);
				end else if (!(kernel_background_enable && priv)) begin // RULE3 RULE2
					bg1 = 1'b1; // RULE25
				end
			end
		end
		// Stage 2
		s2_on = second_stage_enable && req.lvl != pds_pkg::LVL_HYP;
		if (s2_on) begin
			ok2 = !(req.fetch && hbg.xn);
			if (hyp_unit_enable) begin // RULE22
				if (|hhit) begin
					a2 = rattr(hr);
					ok2 = perm_ok(hr.base[pds_pkg::B_AP +: 2], a2.xn, 1'b1, req.write,
						req.fetch);
				end else begin
					bg2 = 1'b1; // RULE25
				end
			end
		end
		// Combine
		ac = a1;
		if (s2_on) begin
			ac.mem = (a2.mem < a1.mem) ? a2.mem : a1.mem; // RULE24
			ac.share = a1.share | a2.share;
			ac.xn = a1.xn | a2.xn;
		end
		next_st.resp.valid = req.valid;
		next_st.resp.attr = ac;
		next_st.resp.level = pds_pkg::FAULT_LEVEL; // RULE18
		if (bg1) begin
			next_st.resp.fault = pds_pkg::FK_BG;
		end else if (!ok1) begin
			next_st.resp.fault = pds_pkg::FK_S1_PERM; // RULE23
		end else if (bg2) begin
			next_st.resp.fault = pds_pkg::FK_BG;
		end else if (!ok2) begin
			next_st.resp.fault = pds_pkg::FK_S2_PERM; // RULE23
		end else begin
			next_st.resp.fault = pds_pkg::FK_NONE;
		end
		next_st.resp.debug_event = req.valid && halting_debug_disable && req.debug &&
			ok1 && !bg1 && (bg2 || !ok2); // RULE19
		next_st.resp.query = '0;
		next_st.resp.query[pds_pkg::Q_F] = next_st.resp.fault != pds_pkg::FK_NONE;
		next_st.resp.query[pds_pkg::Q_FK +: 2] = next_st.resp.fault;
		next_st.resp.query[pds_pkg::Q_LV +: 2] = pds_pkg::FAULT_LEVEL;
		next_st.resp.query[pds_pkg::Q_PA +: 20] = req.addr[31:pds_pkg::Q_PA]; // RULE18
		next_st.resp.query[pds_pkg::Q_AT +: 5] = ac;
		// Region programming, selected or direct index
		cidx = cfg.idx;
		if (cfg.op == pds_pkg::OP_BASE || cfg.op == pds_pkg::OP_LIMIT) begin
			cidx = cfg.hyp ? st.hsel : st.ksel; // RULE15
		end
		unique case (cfg.op)
			pds_pkg::OP_SELECT: begin
				next_st.rdata = 32'(cfg.hyp ? st.hsel : st.ksel);
			end
			pds_pkg::OP_BASE, pds_pkg::OP_DBASE: begin
				next_st.rdata = cfg.hyp ? st.hrgn[cidx].base : st.krgn[cidx].base; // RULE16
			end
			pds_pkg::OP_LIMIT, pds_pkg::OP_DLIMIT: begin
				next_st.rdata = cfg.hyp ? st.hrgn[cidx].limit : st.krgn[cidx].limit;
			end
			default: begin
				for (int i = 0; i < pds_pkg::NRGN; i++) begin
					next_st.rdata[i] = st.hrgn[i].limit[pds_pkg::L_EN]; // RULE17
				end
			end
		endcase
		if (cfg.wr) begin
			unique case (cfg.op)
				pds_pkg::OP_SELECT: begin
					if (cfg.hyp) begin
						next_st.hsel = cfg.wdata[pds_pkg::IDXW-1:0];
					end else begin
						next_st.ksel = cfg.wdata[pds_pkg::IDXW-1:0];
					end
				end
				pds_pkg::OP_BASE, pds_pkg::OP_DBASE: begin
					if (cfg.hyp) begin
						next_st.hrgn[cidx].base = cfg.wdata; // RULE15 RULE16
					end else begin
						next_st.krgn[cidx].base = cfg.wdata; // RULE15 RULE16
					end
				end
				pds_pkg::OP_LIMIT, pds_pkg::OP_DLIMIT: begin
					if (cfg.hyp) begin
						next_st.hrgn[cidx].limit = cfg.wdata;
					end else begin
						next_st.krgn[cidx].limit = cfg.wdata;
					end
				end
				default: begin
					for (int i = 0; i < pds_pkg::NRGN; i++) begin
						next_st.hrgn[i].limit[pds_pkg::L_EN] = cfg.wdata[i]; // RULE17
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg_rdata = st.rdata;
	assign resp = st.resp;

	// ==========================================
	// Checks
	AST_KDIS_DEVICE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
		req.valid && !req.fetch && req.addr >= pds_pkg::DEV_NE_BASE && !second_stage_enable
		&& req.lvl == pds_pkg::LVL_KERNEL && !kernel_unit_enable
		&& !default_cacheable_override |=> resp.attr.mem == pds_pkg::MT_DEV_SO)
		else $error("default data top quarter not strictly ordered");
	AST_KDIS_FETCH_XN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
		req.valid && req.fetch && req.addr >= pds_pkg::DEV_E_BASE && !kernel_unit_enable
		&& !default_cacheable_override && req.lvl != pds_pkg::LVL_HYP && !second_stage_enable
		|=> resp.fault == pds_pkg::FK_S1_PERM && resp.attr.xn)
		else $error("upper half fetch not execute-never");
	AST_DC_OVERRIDE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
		req.valid && default_cacheable_override && !kernel_unit_enable
		&& req.lvl == pds_pkg::LVL_KERNEL && !second_stage_enable
		|=> resp.attr == pds_pkg::DC_ATTR)
		else $error("override attributes wrong");
	AST_KDATA_WB: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
		req.valid && !req.fetch && req.addr <= pds_pkg::WB_TOP && kernel_dcache_enable
		&& !kernel_unit_enable && !default_cacheable_override
		&& req.lvl == pds_pkg::LVL_APP && !second_stage_enable
		|=> resp.attr.mem == pds_pkg::MT_NORM_WB && !resp.attr.share)
		else $error("low data not write-back");
	AST_HYP_DIS: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE20
		req.valid && req.lvl == pds_pkg::LVL_HYP && !hyp_unit_enable && !req.fetch
		&& req.addr > pds_pkg::NC_TOP |=> resp.fault == pds_pkg::FK_NONE
		&& resp.attr.mem inside {pds_pkg::MT_DEV_PW, pds_pkg::MT_DEV_SO})
		else $error("hyp background not applied");
	AST_APP_MISS: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE25
		req.valid && req.lvl == pds_pkg::LVL_APP && kernel_unit_enable && khit == '0
		|=> resp.fault == pds_pkg::FK_BG && resp.query[pds_pkg::Q_F])
		else $error("unprivileged miss did not fault");
	AST_S2_DEV_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE24
		req.valid && second_stage_enable && req.lvl == pds_pkg::LVL_KERNEL && !req.fetch
		&& !hyp_unit_enable && req.addr >= pds_pkg::DEV_NE_BASE
		|=> resp.attr.mem == pds_pkg::MT_DEV_SO)
		else $error("stage 2 device did not prevail");
	AST_DEBUG_EVT: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE19
		resp.debug_event |-> resp.fault == pds_pkg::FK_S2_PERM || resp.fault == pds_pkg::FK_BG)
		else $error("debug event without stage 2 fault");
	AST_LEVEL0: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
		resp.valid |-> resp.level == pds_pkg::FAULT_LEVEL
		&& resp.query[pds_pkg::Q_F] == (resp.fault != pds_pkg::FK_NONE))
		else $error("fault level or query flag wrong");
	AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
		cfg.wr && !cfg.hyp && cfg.op == pds_pkg::OP_SELECT ##1
		!cfg.wr && !cfg.hyp && cfg.op == pds_pkg::OP_SELECT
		|=> cfg_rdata == 32'($past(cfg.wdata[pds_pkg::IDXW-1:0], 2)))
		else $error("select readback wrong");
endmodule : pds_select

// ==== tb/pds_core_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Core pipeline model: presents one access per call
module pds_core_model (
	// Clock
	input wire logic ref_clk,
	// Access channel
	output pds_pkg::pds_req_t req,
	input wire pds_pkg::pds_resp_t resp
);
	initial begin
		req = '0;
	end

	// ==========================================
	// Called at a falling edge; returns the answer of the following rising edge
	task automatic issue(input logic [31:0] addr, input logic fetch, input logic write,
			input pds_pkg::pds_lvl_t lvl, input logic dbg, output pds_pkg::pds_resp_t r);
		req.valid = 1'b1;
		req.addr = addr;
		req.fetch = fetch;
		req.write = write;
		req.lvl = lvl;
		req.debug = dbg;
		@(negedge ref_clk);
		r = resp;
		req.valid = 1'b0;
		// Idle address inverted so a stale value never passes for a live one
		req.addr = ~addr;
		req.write = ~write;
		@(negedge ref_clk);
	endtask : issue
endmodule : pds_core_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`define check(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
	// ==========================================
	// Shorthands
	localparam pds_pkg::pds_mem_t SO = pds_pkg::MT_DEV_SO, PW = pds_pkg::MT_DEV_PW,
		NC = pds_pkg::MT_NORM_NC, WT = pds_pkg::MT_NORM_WT, WB = pds_pkg::MT_NORM_WB;
	localparam pds_pkg::pds_fault_t F0 = pds_pkg::FK_NONE, S1 = pds_pkg::FK_S1_PERM,
		S2 = pds_pkg::FK_S2_PERM, BG = pds_pkg::FK_BG;
	localparam pds_pkg::pds_lvl_t APP = pds_pkg::LVL_APP, KRN = pds_pkg::LVL_KERNEL,
		HYP = pds_pkg::LVL_HYP;
	// ==========================================
	// Signals
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic kernel_unit_enable = 1'b0, hyp_unit_enable = 1'b0;
	logic kernel_background_enable = 1'b0, hyp_background_enable = 1'b0;
	logic default_cacheable_override = 1'b0, second_stage_enable = 1'b0;
	logic kernel_icache_enable = 1'b0, kernel_dcache_enable = 1'b0;
	logic hyp_icache_enable = 1'b0, hyp_dcache_enable = 1'b0, halting_debug_disable = 1'b0;
	pds_pkg::pds_cfg_t cfg = '0;
	logic [31:0] cfg_rdata;
	pds_pkg::pds_req_t req;
	pds_pkg::pds_resp_t resp;
	int failures = 0;
	int comparisons = 0;
	logic dbg_ev;

	always #10 ref_clk = ~ref_clk;

	pds_select u_pds_select (.ref_clk, .arst_n, .kernel_unit_enable, .hyp_unit_enable,
		.kernel_background_enable, .hyp_background_enable, .default_cacheable_override,
		.second_stage_enable, .kernel_icache_enable, .kernel_dcache_enable,
		.hyp_icache_enable, .hyp_dcache_enable, .halting_debug_disable, .cfg,
		.cfg_rdata, .req, .resp);

	pds_core_model u_pds_core_model (.ref_clk(ref_clk), .req(req), .resp(resp));

	// ==========================================
	// Access helpers
	task automatic cfg_op(input logic h, input pds_pkg::pds_op_t op, input logic [4:0] idx,
			input logic [31:0] wd, input logic wr, output logic [31:0] rd);
		cfg.wr = wr;
		cfg.hyp = h;
		cfg.op = op;
		cfg.idx = idx;
		cfg.wdata = wd;
		@(negedge ref_clk);
		rd = cfg_rdata;
	endtask : cfg_op

	task automatic rdchk(input logic h, input pds_pkg::pds_op_t op, input logic [4:0] idx,
			input logic [31:0] exp);
		logic [31:0] rd;
		cfg_op(h, op, idx, 32'h00000000, 1'b0, rd);
		`check(rd, exp)
	endtask : rdchk

	// sh: bit1 set means shareability not compared
	task automatic acc(input logic [31:0] a, input logic f, input logic w,
			input pds_pkg::pds_lvl_t l, input logic dbg, input pds_pkg::pds_fault_t fk,
			input pds_pkg::pds_mem_t m, input logic [1:0] sh);
		pds_pkg::pds_resp_t r;
		u_pds_core_model.issue(a, f, w, l, dbg, r);
		`check(r.valid, 1'b1)
		`check(r.query[4:3], pds_pkg::FAULT_LEVEL)
		if (f) `check(r.attr.xn, fk != F0)
		`check(r.fault, fk)
		`check(r.level, pds_pkg::FAULT_LEVEL)
		`check(r.query[31:12], a[31:12])
		`check(r.query[2:0], {fk, fk != F0})
		if (fk == F0) begin
			`check(r.attr.mem, m)
			`check(r.query[36:34], m)
			if (!sh[1]) `check(r.attr.share, sh[0])
		end
		dbg_ev = r.debug_event;
	endtask : acc

	task automatic summarize;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// ==========================================
	// Watchdog: the sequence needs about 133 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		summarize();
	end

	// ==========================================
	// Main sequence
	initial begin
		static logic [31:0] da [6] = '{32'h3fffffff, 32'h40000000, 32'h5fffffff,
			32'h60000000, 32'hbfffffff, 32'hc0000000};
		static pds_pkg::pds_mem_t m1 [6] = '{WB, WT, WT, NC, PW, SO};
		static pds_pkg::pds_mem_t m0 [6] = '{NC, NC, NC, NC, PW, SO};
		static logic [1:0] s1 [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
		static logic [1:0] s0 [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
		logic [31:0] rd;
		repeat (3) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		// Default maps: the other unit's cache bits set opposite to prove selection
		for (int u = 0; u < 2; u++) begin
			for (int c = 0; c < 2; c++) begin
				kernel_dcache_enable = c[0] ^ u[0];
				kernel_icache_enable = c[0] ^ u[0];
				hyp_dcache_enable = ~(c[0] ^ u[0]);
				hyp_icache_enable = ~(c[0] ^ u[0]);
				for (int i = 0; i < 6; i++)
					acc(da[i], 1'b0, 1'b0, u ? HYP : KRN, 1'b0, F0, c ? m1[i] : m0[i],
						c ? s1[i] : s0[i]);
				acc(32'h7fffffff, 1'b1, 1'b0, u ? HYP : KRN, 1'b0, F0, c ? WT : NC,
					c ? 2'h0 : 2'h1);
				acc(32'h80000000, 1'b1, 1'b0, u ? HYP : KRN, 1'b0, S1, SO, 2'h2);
			end
		end
		// Cacheable override touches the kernel side only
		default_cacheable_override = 1'b1;
		acc(32'hc0000000, 1'b0, 1'b1, KRN, 1'b0, F0, WB, 2'h0);
		acc(32'h80000000, 1'b1, 1'b0, KRN, 1'b0, F0, WB, 2'h0);
		acc(32'hc0000000, 1'b0, 1'b0, HYP, 1'b0, F0, SO, 2'h2);
		default_cacheable_override = 1'b0;
		// Kernel region 3 through the select, read-only and privileged only
		cfg_op(1'b0, pds_pkg::OP_SELECT, 5'h00, 32'h00000003, 1'b1, rd);
		rdchk(1'b0, pds_pkg::OP_SELECT, 5'h00, 32'h00000003);
		cfg_op(1'b0, pds_pkg::OP_BASE, 5'h00, 32'h00100004, 1'b1, rd);
		cfg_op(1'b0, pds_pkg::OP_LIMIT, 5'h00, 32'h001fffc9, 1'b1, rd);
		rdchk(1'b0, pds_pkg::OP_BASE, 5'h00, 32'h00100004);
		rdchk(1'b0, pds_pkg::OP_DLIMIT, 5'h03, 32'h001fffc9);
		cfg_op(1'b0, pds_pkg::OP_DBASE, 5'h1f, 32'habcdef40, 1'b1, rd);
		rdchk(1'b0, pds_pkg::OP_DBASE, 5'h1f, 32'habcdef40);
		kernel_unit_enable = 1'b1;
		kernel_dcache_enable = 1'b1;
		acc(32'h00100040, 1'b0, 1'b0, KRN, 1'b0, F0, WB, 2'h0);
		acc(32'h001fffff, 1'b0, 1'b1, KRN, 1'b0, S1, WB, 2'h2);
		acc(32'h00100040, 1'b0, 1'b0, APP, 1'b0, S1, WB, 2'h2);
		acc(32'h00200000, 1'b0, 1'b0, KRN, 1'b0, BG, WB, 2'h2);
		kernel_background_enable = 1'b1;
		acc(32'h00200000, 1'b0, 1'b0, KRN, 1'b0, F0, WB, 2'h0);
		acc(32'h00200000, 1'b0, 1'b0, APP, 1'b0, BG, WB, 2'h2);
		kernel_unit_enable = 1'b0;
		acc(32'h00100040, 1'b0, 1'b1, KRN, 1'b0, F0, WB, 2'h0);
		acc(32'h00000040, 1'b0, 1'b0, APP, 1'b0, F0, WB, 2'h0);
		kernel_unit_enable = 1'b1;
		// Hypervisor region 0: read-only posted device over the low 16MB
		cfg_op(1'b1, pds_pkg::OP_DBASE, 5'h00, 32'h00000006, 1'b1, rd);
		cfg_op(1'b1, pds_pkg::OP_DLIMIT, 5'h00, 32'h00ffffc2, 1'b1, rd);
		cfg_op(1'b1, pds_pkg::OP_ENABLES, 5'h00, 32'h00000021, 1'b1, rd);
		rdchk(1'b1, pds_pkg::OP_ENABLES, 5'h00, 32'h00000021);
		cfg_op(1'b0, pds_pkg::OP_ENABLES, 5'h00, 32'h00000001, 1'b1, rd);
		rdchk(1'b1, pds_pkg::OP_DLIMIT, 5'h00, 32'h00ffffc3);
		cfg_op(1'b1, pds_pkg::OP_SELECT, 5'h00, 32'h00000005, 1'b1, rd);
		rdchk(1'b1, pds_pkg::OP_SELECT, 5'h00, 32'h00000005);
		rdchk(1'b1, pds_pkg::OP_LIMIT, 5'h00, 32'h00000000);
		hyp_unit_enable = 1'b1;
		second_stage_enable = 1'b1;
		acc(32'h00100040, 1'b0, 1'b0, KRN, 1'b0, F0, PW, 2'h2);
		acc(32'h00100040, 1'b0, 1'b1, KRN, 1'b0, S1, WB, 2'h2);
		acc(32'h00200000, 1'b0, 1'b1, KRN, 1'b1, S2, WB, 2'h2);
		`check(dbg_ev, 1'b0)
		halting_debug_disable = 1'b1;
		acc(32'h00200000, 1'b0, 1'b1, KRN, 1'b1, S2, WB, 2'h2);
		`check(dbg_ev, 1'b1)
		acc(32'h01000000, 1'b0, 1'b0, KRN, 1'b0, BG, WB, 2'h2);
		acc(32'h00200000, 1'b0, 1'b0, HYP, 1'b0, F0, PW, 2'h2);
		acc(32'h01000000, 1'b0, 1'b0, HYP, 1'b0, BG, WB, 2'h2);
		hyp_background_enable = 1'b1;
		hyp_dcache_enable = 1'b1;
		acc(32'h01000000, 1'b0, 1'b0, HYP, 1'b0, F0, WB, 2'h0);
		// Stage 2 from the hypervisor background once its unit is off
		hyp_unit_enable = 1'b0;
		acc(32'h00100040, 1'b0, 1'b0, KRN, 1'b0, F0, WB, 2'h0);
		hyp_dcache_enable = 1'b0;
		acc(32'h00100040, 1'b0, 1'b0, KRN, 1'b0, F0, NC, 2'h1);
		acc(32'h00100040, 1'b0, 1'b0, HYP, 1'b0, F0, NC, 2'h1);
		// Normal stage 1 against device stage 2: the device side must prevail
		default_cacheable_override = 1'b1;
		acc(32'hc0000000, 1'b0, 1'b0, KRN, 1'b0, F0, SO, 2'h2);
		default_cacheable_override = 1'b0;
		summarize();
	end
endmodule : tb_top
